// [logic/aep_top.v]
// absolute encoder position output: parallel word and synchronous serial frame
// assumes position samples arrive on pclk from the sensing logic; pins are async
//
// Contract
// R1 - direction input open reads high; high counts up clockwise
// R2 - for counterclockwise up-count the user ties direction input low
// R3 - driver-on low enables parallel drivers; open defaults low
// R4 - driver-on high puts every parallel output in high impedance; here only the data lines float, the parity line stays driven
// R5 - freeze low captures current position into a gray holding register
// R6 - parallel value constant while frozen; open freeze reads high
// R7 - binary readers should freeze before sampling
// R8 - parity output high when checksum over presented bits is even
// R9 - zero input held over 100 ms sets current position to zero
// R10 - frame layout for up to 13 bits, another for 14-15 bits
// R11 - serial position sent msb first, left aligned in data field
// R12 - high resolution frame: 15 data bits, then fault, then monitor flag
// R13 - fault flag set since last transfer, cleared by next transfer
// R14 - parallel refresh every 60 us gray/binary, 200 us bcd
// R15 - external master clocks the frame; position latched at frame start
// R16 - parallel lines carry binary, gray or bcd with fixed bit weights
//
// Chosen here: the address map and the APB register port.
`timescale 1ns/1ps
`include "aep_defs.vh"
module aep_top #(
    parameter PW       = 15,                  // position width
    parameter CODE     = 0,                   // 0 binary, 1 gray, 2 bcd
    parameter ZERO_CYC = `AEP_ZERO_CYC,       // zero hold cycles
    parameter RPT_GB   = `AEP_RPT_GB_CYC,     // refresh, gray and binary
    parameter RPT_BCD  = `AEP_RPT_BCD_CYC,    // refresh, bcd
    parameter MONO_CYC = `AEP_MONO_CYC        // serial idle timeout
) (
    input  wire          pclk,        // clock 125 MHz
    input  wire          presetn,     // async reset, active low
    input  wire          psel,        // apb select
    input  wire          penable,     // apb enable
    input  wire          pwrite,      // apb write
    input  wire [11:0]   paddr,       // apb byte address
    input  wire [31:0]   pwdata,      // apb write data
    output reg  [31:0]   prdata,      // apb read data
    output wire          pready,      // apb ready
    output wire          pslverr,     // apb error
    input  wire [PW-1:0] pos_data,    // raw clockwise count
    input  wire          pos_fault,   // detection fault with this sample
    input  wire          pos_valid,   // sample valid
    output wire          pos_ready,   // buffer room
    input  wire          tx_fault,    // transmitter monitor state
    input  wire          dir_pin,     // count direction pin
    input  wire          drv_on_n,    // parallel driver enable, active low
    input  wire          freeze_n,    // freeze pin, active low
    input  wire          zero_pin,    // electronic zeroing pin
    input  wire          ssi_clk,     // serial clock from master
    output reg           ssi_data,    // serial data out
    output reg  [PW-1:0] par_out,     // parallel data lines
    output reg  [PW-1:0] par_oe,      // parallel line enables
    output reg           parity_out   // parity line
);
    // ********************************************
    // pin synchronisers
    // ********************************************
    reg [4:0] s1_r;
    reg [4:0] s2_r;
    reg       sclk_d_r;
    reg       frz_d_r;
    wire      dir_s  = s2_r[0];
    wire      drv_s  = s2_r[1];
    wire      frz_s  = s2_r[2];
    wire      zero_s = s2_r[3];
    wire      sclk_s = s2_r[4];

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            // idle levels: direction up, drivers on, not frozen, clock high
            s1_r     <= 5'h15;
            s2_r     <= 5'h15;
            sclk_d_r <= 1'b1;
            frz_d_r  <= 1'b1;
        end else begin
            s1_r     <= {ssi_clk, zero_pin, freeze_n, drv_on_n, dir_pin};
            // only the second stage feeds logic
            s2_r     <= s1_r;
            sclk_d_r <= sclk_s;
            frz_d_r  <= frz_s;
        end
    end

    // falling edge opens a frame, rising edges shift it
    wire sclk_fall = sclk_d_r & ~sclk_s;
    wire sclk_rise = ~sclk_d_r & sclk_s;

    // ********************************************
    // helpers
    // ********************************************
    function [PW-1:0] to_gray;
        input [PW-1:0] b;
        begin
            to_gray = b ^ (b >> 1);
        end
    endfunction

    function [PW-1:0] from_gray;
        input [PW-1:0] g;
        integer i;
        begin
            from_gray[PW-1] = g[PW-1];
            for (i = PW - 2; i >= 0; i = i - 1) begin
                from_gray[i] = from_gray[i+1] ^ g[i];
            end
        end
    endfunction

    // double dabble, digits of 4 bits with fixed weights
    function [PW-1:0] to_bcd;
        input [PW-1:0] b;
        integer i;
        integer d;
        reg [PW+15:0] sh;
        begin
            sh = {16'h0000, b};
            for (i = 0; i < PW; i = i + 1) begin
                for (d = 0; d < 4; d = d + 1) begin
                    if (sh[PW+4*d +: 4] > 4'h4) begin
                        sh[PW+4*d +: 4] = sh[PW+4*d +: 4] + 4'h3;
                    end
                end
                sh = sh << 1;
            end
            to_bcd = sh[PW +: PW];
        end
    endfunction

    // ********************************************
    // registers
    // ********************************************
    reg  [1:0]    code_r;
    reg  [3:0]    res_r;
    reg  [PW-1:0] zero_ofs_r;
    reg  [PW-1:0] pos_r;
    reg  [PW-1:0] hold_gray_r;
    reg           fault_r;
    reg           busy_r;
    reg  [PW-1:0] raw_r;
    wire          apb_wr  = psel & penable & pwrite;
    // read data loads in the setup cycle and stands through the access phase
    wire          apb_rd  = psel & ~penable & ~pwrite;
    wire          map_hit = (paddr == `AEP_CTRL_OFS) || (paddr == `AEP_STAT_OFS) ||
                            (paddr == `AEP_ZERO_OFS) || (paddr == `AEP_PAR_OFS);

    // zero wait states; unmapped addresses answer with an error
    assign pready  = 1'b1;
    assign pslverr = psel & penable & ~map_hit;

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
        end else if (apb_rd) begin
            case (paddr)
                `AEP_CTRL_OFS: prdata <= {24'h00_0000, res_r, 2'h0, code_r};
                `AEP_STAT_OFS: prdata <= {12'h000, dir_s, busy_r, ~frz_s, fault_r,
                                          {(16-PW){1'b0}}, pos_r};
                `AEP_ZERO_OFS: prdata <= {{(32-PW){1'b0}}, zero_ofs_r};
                `AEP_PAR_OFS:  prdata <= {{(31-PW){1'b0}}, parity_out, par_out};
                default:       prdata <= 32'h0000_0000;
            endcase
        end
    end

    // ********************************************
    // position sample buffer and refresh
    // ********************************************
    wire [PW:0]   buf_data;
    wire          buf_valid;
    reg  [14:0]   rpt_cnt_r;
    wire [14:0]   rpt_lim = (code_r == `AEP_CODE_BCD) ? RPT_BCD[14:0] : RPT_GB[14:0];
    // refresh tick pops at most one sample
    wire          rpt_tick = (rpt_cnt_r >= rpt_lim - 15'h0001);

    // two entries absorb a stall until the next refresh
    aep_buf2 #(
        .W(PW + 1)
    ) u_buf (
        .pclk      (pclk),
        .presetn   (presetn),
        .in_data   ({pos_fault, pos_data}),
        .in_valid  (pos_valid),
        .in_ready  (pos_ready),
        .out_data  (buf_data),
        .out_valid (buf_valid),
        .out_ready (rpt_tick)
    );

    // R1 direction and offset
    wire [PW-1:0] dir_pos = dir_s ? buf_data[PW-1:0] : (~buf_data[PW-1:0] + 1'b1);
    wire [PW-1:0] res_mask = ~({PW{1'b1}} << res_r);
    reg  [23:0]   zero_cnt_r;
    wire          zero_done = (zero_cnt_r == ZERO_CYC[23:0]);
    wire          frame_load;
    wire          pos_pop = rpt_tick & buf_valid;

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            code_r     <= CODE[1:0];
            res_r      <= `AEP_RES_RST;
            zero_ofs_r <= {PW{1'b0}};
            zero_cnt_r <= 24'h00_0000;
            rpt_cnt_r  <= 15'h0000;
            pos_r      <= {PW{1'b0}};
            raw_r      <= {PW{1'b0}};
            fault_r    <= 1'b0;
        end else begin
            if (apb_wr && paddr == `AEP_CTRL_OFS) begin
                code_r <= pwdata[`AEP_CODE_MSB:`AEP_CODE_LSB];
                res_r  <= pwdata[`AEP_RES_MSB:`AEP_RES_LSB];
            end
            // R14 refresh spacing
            rpt_cnt_r <= rpt_tick ? 15'h0000 : rpt_cnt_r + 15'h0001;
            // R9 zero after long hold
            if (!zero_s) begin
                zero_cnt_r <= 24'h00_0000;
            end else if (!zero_done) begin
                zero_cnt_r <= zero_cnt_r + 24'h00_0001;
            end
            // offset is the last refreshed raw count, not the buffer head
            if (zero_s && zero_cnt_r == ZERO_CYC[23:0] - 24'h00_0001) begin
                zero_ofs_r <= raw_r;
            end else if (apb_wr && paddr == `AEP_ZERO_OFS) begin
                zero_ofs_r <= pwdata[PW-1:0];
            end
            if (pos_pop) begin
                raw_r <= dir_pos;
            end
            // every refresh recomputes, so a new offset shows without a new sample
            if (rpt_tick) begin
                pos_r <= ((pos_pop ? dir_pos : raw_r) - zero_ofs_r) & res_mask;
            end
            // R13 set wins over the frame clear
            if (pos_pop && buf_data[PW]) begin
                fault_r <= 1'b1;
            end else if (frame_load) begin
                fault_r <= 1'b0;
            end
        end
    end

    // ********************************************
    // parallel output
    // ********************************************
    reg  [PW-1:0] pres_bin;
    reg  [PW-1:0] pres_word;

    always @* begin
        // R6 frozen value comes from the holding register
        // first frozen cycle shows the word being captured
        pres_bin = (frz_s || frz_d_r) ? pos_r : from_gray(hold_gray_r);
        // R16 code selection
        case (code_r)
            `AEP_CODE_BIN:  pres_word = pres_bin;
            `AEP_CODE_GRAY: pres_word = to_gray(pres_bin);
            `AEP_CODE_BCD:  pres_word = to_bcd(pres_bin);
            default:        pres_word = pres_bin;
        endcase
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            hold_gray_r <= {PW{1'b0}};
            par_out     <= {PW{1'b0}};
            par_oe      <= {PW{1'b0}};
            parity_out  <= 1'b1;
        end else begin
            // R5 capture gray on freeze falling edge
            if (frz_d_r && !frz_s) begin
                hold_gray_r <= to_gray(pos_r);
            end
            par_out    <= pres_word;
            // R3 R4 drivers follow driver-on
            par_oe     <= {PW{~drv_s}};
            // R8 high on even checksum
            parity_out <= ~^pres_word;
        end
    end

    // ********************************************
    // serial frame
    // ********************************************
    reg  [16:0]   shift_r;
    reg  [4:0]    bits_r;
    reg  [11:0]   mono_r;
    // above 13 bits the long frame with error bits
    wire          hires = (res_r > `AEP_LORES_MAX);
    wire [PW-1:0] gray_now = to_gray(pos_r);
    wire [PW-1:0] left_al = gray_now << (PW[3:0] - res_r);

    assign frame_load = sclk_fall & ~busy_r;

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            shift_r  <= 17'h0_0000;
            bits_r   <= 5'h00;
            mono_r   <= 12'h000;
            busy_r   <= 1'b0;
            ssi_data <= 1'b1;
        end else begin
            if (frame_load) begin
                // R15 latch at frame start
                busy_r <= 1'b1;
                mono_r <= 12'h000;
                // R10 R11 R12 layouts, msb first
                if (hires) begin
                    shift_r <= {left_al, fault_r, tx_fault};
                    bits_r  <= `AEP_FRAME_HI;
                end else begin
                    shift_r <= {left_al[PW-1:PW-13], 4'h0};
                    bits_r  <= `AEP_FRAME_LO;
                end
            end else if (busy_r) begin
                if (sclk_rise) begin
                    // R15 one bit per clock
                    mono_r <= 12'h000;
                    if (bits_r != 5'h00) begin
                        ssi_data <= shift_r[16];
                        shift_r  <= {shift_r[15:0], 1'b0};
                        bits_r   <= bits_r - 5'h01;
                    end else begin
                        // past the last bit data stays low until the rest
                        ssi_data <= 1'b0;
                    end
                // clock resting high ends the frame after the timeout
                end else if (sclk_s) begin
                    if (mono_r == MONO_CYC[11:0]) begin
                        busy_r   <= 1'b0;
                        ssi_data <= 1'b1;
                    end else begin
                        mono_r <= mono_r + 12'h001;
                    end
                end else begin
                    mono_r <= 12'h000;
                end
            end
        end
    end
endmodule

// [pkg/aep_defs.vh]
// constants of the absolute encoder position output block
// included by the top design file and the bench; definitions only
`ifndef AEP_DEFS_VH
`define AEP_DEFS_VH

// ********************************************
// register byte offsets
// ********************************************
`define AEP_CTRL_OFS      12'h000
`define AEP_STAT_OFS      12'h004
`define AEP_ZERO_OFS      12'h008
`define AEP_PAR_OFS       12'h00c

// ********************************************
// control fields and reset values
// ********************************************
`define AEP_CODE_LSB      0
`define AEP_CODE_MSB      1
`define AEP_RES_LSB       4
`define AEP_RES_MSB       7
`define AEP_CODE_BIN      2'h0
`define AEP_CODE_GRAY     2'h1
`define AEP_CODE_BCD      2'h2
`define AEP_RES_RST       4'hd

// ********************************************
// status fields
// ********************************************
`define AEP_ST_FAULT      16
`define AEP_ST_FROZEN     17
`define AEP_ST_BUSY       18
`define AEP_ST_DIR        19

// ********************************************
// serial frame
// ********************************************
`define AEP_LORES_MAX     4'hd
`define AEP_FRAME_LO      5'h0d
`define AEP_FRAME_HI      5'h11

// ********************************************
// timing: clock rate and printed times
// ********************************************
`define AEP_CLK_MHZ       125
`define AEP_ZERO_MS       100
`define AEP_RPT_GB_US     60
`define AEP_RPT_BCD_US    200
`define AEP_MONO_US       20
`define AEP_ZERO_CYC      (`AEP_ZERO_MS * 1000 * `AEP_CLK_MHZ)
`define AEP_RPT_GB_CYC    (`AEP_RPT_GB_US * `AEP_CLK_MHZ)
`define AEP_RPT_BCD_CYC   (`AEP_RPT_BCD_US * `AEP_CLK_MHZ)
`define AEP_MONO_CYC      (`AEP_MONO_US * `AEP_CLK_MHZ)

`endif

// [logic/aep_buf2.v]
// two-entry buffer with valid and ready on both sides
// assumes one clock, asynchronous active-low reset
`timescale 1ns/1ps
module aep_buf2 #(
    parameter W = 16
) (
    input  wire         pclk,     // clock
    input  wire         presetn,  // reset, active low
    input  wire [W-1:0] in_data,  // word in
    input  wire         in_valid, // word in valid
    output wire         in_ready, // room for a word
    output wire [W-1:0] out_data, // oldest word
    output wire         out_valid,// a word is held
    input  wire         out_ready // drain side takes it
);
    reg [W-1:0] m0_r;
    reg [W-1:0] m1_r;
    reg [1:0]   cnt_r;
    wire        push;
    wire        pop;

    assign in_ready  = (cnt_r != 2'h2);
    assign out_valid = (cnt_r != 2'h0);
    assign out_data  = m0_r;
    assign push      = in_valid & in_ready;
    assign pop       = out_valid & out_ready;

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            m0_r  <= {W{1'b0}};
            m1_r  <= {W{1'b0}};
            cnt_r <= 2'h0;
        end else begin
            // entry 0 is the head
            if (pop) begin
                m0_r <= (cnt_r == 2'h2) ? m1_r : in_data;
            end else if (push && cnt_r == 2'h0) begin
                m0_r <= in_data;
            end
            if (push && ((cnt_r == 2'h1 && !pop) || (cnt_r == 2'h2 && pop))) begin
                m1_r <= in_data;
            end
            if (push && !pop) begin
                cnt_r <= cnt_r + 2'h1;
            end else if (pop && !push) begin
                cnt_r <= cnt_r - 2'h1;
            end
        end
    end
endmodule

// [dv/aep_top_monitor.sv]
// checker of the position output block, sees only ports of aep_top
// bound from the bench top; one pclk domain, async active-low reset
`timescale 1ns/1ps
module aep_top_monitor #(
    parameter PW       = 15,
    parameter ZERO_CYC = 50,
    parameter RPT_BCD  = 20,
    parameter MONO_CYC = 40
) (
    input wire          pclk,      // clock
    input wire          presetn,   // reset, active low
    input wire          pos_ready, // buffer room
    input wire          drv_on_n,  // driver enable, active low
    input wire          freeze_n,  // freeze, active low
    input wire          zero_pin,  // zero request
    input wire          ssi_clk,   // serial clock
    input wire          ssi_data,  // serial data
    input wire [PW-1:0] par_out,   // parallel word
    input wire [PW-1:0] par_oe,    // parallel enables
    input wire          parity_out // parity line
);
    localparam int RPT_WIN  = RPT_BCD + 4;
    localparam int ZERO_CHK = ZERO_CYC + RPT_BCD + 10;
    integer hi_cnt;
    integer zero_cnt;

    // ****************************************
    // cycle counters and properties
    // ****************************************
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            hi_cnt   <= 0;
            zero_cnt <= 0;
        end else begin
            hi_cnt   <= ssi_clk ? hi_cnt + 1 : 0;
            zero_cnt <= zero_pin ? zero_cnt + 1 : 0;
        end
    end
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    drv_off_a: assert property (drv_on_n [*5] |-> par_oe == '0)
        else $error("parallel lines driven while drivers are off");
    drv_on_a: assert property (!drv_on_n [*5] |-> &par_oe)
        else $error("parallel lines not driven while enabled");
    parity_even_a: assert property (parity_out == ~^par_out)
        else $error("parity line does not match the word");
    freeze_hold_a: assert property (!freeze_n [*5] |-> $stable(par_out))
        else $error("parallel word moved while frozen");
    zero_clear_a: assert property (zero_cnt == ZERO_CHK && freeze_n |-> par_out == '0)
        else $error("long zero request did not clear the word");
    buf_drain_a: assert property (!pos_ready |-> ##[1:RPT_WIN] pos_ready)
        else $error("sample buffer not drained within a refresh");
    data_edge_a: assert property ($changed(ssi_data) |-> ssi_clk && $past(ssi_clk))
        else $error("serial data moved outside a clock high phase");
    serial_idle_a: assert property (hi_cnt > MONO_CYC + 6 |-> ssi_data)
        else $error("serial data not idle after the clock rested");
    cover property ($fell(ssi_clk));
    cover property (!pos_ready);
    cover property (zero_cnt == ZERO_CHK);
    cover property (!freeze_n [*5]);
endmodule

// [dv/aep_ssi_master.sv]
// serial master model: clocks one frame and gathers its bits msb first
// assumes the encoder shifts on the rising edge; clock rests high between frames
`timescale 1ns/1ps
module aep_ssi_master (
    input  wire ssi_data, // serial data from the encoder
    output reg  ssi_clk   // serial clock to the encoder
);
    initial ssi_clk = 1'b1;
    task automatic read_frame(input integer n, input integer half, output logic [16:0] w);
        integer i;
        w = '0;
        ssi_clk = 1'b0;
        for (i = 0; i < n; i++) begin
            #(half);
            ssi_clk = 1'b1;
            #(half);
            ssi_clk = 1'b0;
            w = {w[15:0], ssi_data};
        end
        #(half);
        ssi_clk = 1'b1;
        // rest long enough for the idle timeout
        #(half * 12);
    endtask
endmodule

// [dv/aep_top_tb.sv]
// bench of the position output block: reset checks, table of codes, then hand tests
// assumes the design files, the monitor and the serial master model
`timescale 1ns/1ps
`include "aep_defs.vh"
`define CHK(n, e, g) chk(n, 32'(e), 32'(g))
module aep_top_tb;
    localparam ZC = 50;
    localparam RB = 20;
    logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic [11:0] paddr = 0;
    logic [31:0] pwdata = 0, q;
    logic [14:0] pos_data = 0, p;
    logic        pos_fault = 0, pos_valid = 0, tx_fault = 0, dir_pin = 1;
    logic        drv_on_n = 0, freeze_n = 1, zero_pin = 0, err;
    wire  [31:0] prdata;
    wire  [14:0] par_out, par_oe;
    wire         pready, pslverr, pos_ready, ssi_clk, ssi_data, parity_out;
    logic [16:0] w, e;
    integer      fail_count = 0, cmp_count = 0, cyc = 0, stalls = 0, i, r;
    logic [31:0] rows [0:5] = '{{2'h0, 15'h04d2, 15'h04d2}, {2'h1, 15'h04d2, 15'h06bb},
        {2'h2, 15'h04d2, 15'h1234}, {2'h2, 15'h1f3f, 15'h7999},
        {2'h1, 15'h1fff, 15'h1000}, {2'h0, 15'h1fff, 15'h1fff}};

    always #4 pclk = ~pclk;
    aep_top #(.ZERO_CYC(ZC), .RPT_GB(8), .RPT_BCD(RB), .MONO_CYC(40)) aep_top_i (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .pos_data(pos_data), .pos_fault(pos_fault),
        .pos_valid(pos_valid), .pos_ready(pos_ready), .tx_fault(tx_fault),
        .dir_pin(dir_pin), .drv_on_n(drv_on_n), .freeze_n(freeze_n), .zero_pin(zero_pin),
        .ssi_clk(ssi_clk), .ssi_data(ssi_data), .par_out(par_out), .par_oe(par_oe),
        .parity_out(parity_out));
    aep_ssi_master aep_ssi_master_i (.ssi_data(ssi_data), .ssi_clk(ssi_clk));

    // ****************************************
    // shared tasks
    // ****************************************
    task automatic chk(input string n, input logic [31:0] ex, input logic [31:0] g);
        cmp_count++;
        if (g !== ex) begin
            fail_count++;
            $display("[FAIL] %s expected %h seen %h", n, ex, g);
        end
    endtask
    task automatic clks(input integer n);
        repeat (n) @(posedge pclk);
    endtask
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        err = pslverr;
        q = prdata;
        psel <= 0;
        penable <= 0;
    endtask
    task automatic push(input logic [14:0] v, input logic f);
        @(posedge pclk);
        pos_data <= v;
        pos_fault <= f;
        pos_valid <= 1;
        @(posedge pclk);
        while (pos_ready !== 1'b1) begin
            stalls++;
            @(posedge pclk);
        end
        pos_valid <= 0;
    endtask
    task automatic stop_test;
        $display("comparisons %0d, mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    always @(posedge pclk) begin
        cyc++;
        if (cyc == 10000) begin
            fail_count++;
            stop_test;
        end
    end

    // ****************************************
    // main sequence
    // ****************************************
    initial begin
        clks(10);
        `CHK("oe in reset", 0, par_oe);
        `CHK("parity in reset", 1, parity_out);
        presetn <= 1;
        apb(0, `AEP_CTRL_OFS, 0);
        `CHK("ctrl reset", 32'h0d0, q);
        apb(0, 12'h010, 0);
        `CHK("unmapped error", 1, err);
        $display("test reset done");
        for (i = 0; i < 6; i++) begin
            apb(1, `AEP_CTRL_OFS, 32'h0d0 | rows[i][31:30]);
            push(rows[i][29:15], 0);
            clks(rows[i][31:30] == `AEP_CODE_BCD ? RB + 8 : 16);
            `CHK("par word", rows[i][14:0], par_out);
            apb(0, `AEP_STAT_OFS, 0);
            `CHK("position", rows[i][29:15], q[14:0]);
            apb(0, `AEP_PAR_OFS, 0);
            `CHK("par parity", ~^rows[i][14:0], q[15]);
        end
        $display("test code table done");
        drv_on_n <= 1;
        clks(6);
        `CHK("tri-state", 0, par_oe);
        drv_on_n <= 0;
        clks(6);
        `CHK("driven", 15'h7fff, par_oe);
        dir_pin <= 0;
        push(15'h0010, 0);
        clks(16);
        apb(0, `AEP_STAT_OFS, 0);
        `CHK("ccw count", 15'h1ff0, q[14:0]);
        `CHK("dir status", 0, q[`AEP_ST_DIR]);
        clks(1);
        dir_pin <= 1;
        $display("test drivers and direction done");
        apb(1, `AEP_CTRL_OFS, 32'h0d1);
        push(15'h0100, 0);
        clks(16);
        freeze_n <= 0;
        clks(6);
        push(15'h0200, 0);
        clks(16);
        `CHK("frozen gray", 15'h0180, par_out);
        freeze_n <= 1;
        clks(16);
        `CHK("live gray", 15'h0300, par_out);
        $display("test freeze done");
        apb(1, `AEP_CTRL_OFS, 32'h0d0);
        clks(1);
        zero_pin <= 1;
        clks(ZC - 10);
        zero_pin <= 0;
        clks(30);
        apb(0, `AEP_STAT_OFS, 0);
        `CHK("short zero", 15'h0200, q[14:0]);
        clks(1);
        zero_pin <= 1;
        clks(ZC + RB + 14);
        zero_pin <= 0;
        apb(0, `AEP_STAT_OFS, 0);
        `CHK("long zero", 0, q[14:0]);
        apb(0, `AEP_ZERO_OFS, 0);
        `CHK("zero offset", 15'h0200, q[14:0]);
        push(15'h0205, 0);
        clks(16);
        apb(0, `AEP_STAT_OFS, 0);
        `CHK("after zero", 15'h0005, q[14:0]);
        apb(1, `AEP_ZERO_OFS, 0);
        $display("test zeroing done");
        apb(1, `AEP_CTRL_OFS, 32'h0d2);
        stalls = 0;
        for (i = 1; i < 5; i++) push(i == 4 ? 15'h04d2 : 15'(i), 0);
        `CHK("buffer refused", 1, stalls > 0);
        clks(4 * RB);
        `CHK("bcd last word", 15'h1234, par_out);
        $display("test buffer done");
        for (r = 15; r > 12; r--) begin
            apb(1, `AEP_CTRL_OFS, (r << 4) | 1);
            tx_fault <= (r == 15);
            push(15'h5a5a, r == 15);
            clks(16);
            apb(0, `AEP_STAT_OFS, 0);
            `CHK("fault flag", r == 15, q[`AEP_ST_FAULT]);
            p = 15'h5a5a & 15'((1 << r) - 1);
            p = p ^ (p >> 1);
            e = r > 13 ? {15'(p << (15 - r)), r == 15, r == 15} : {4'h0, p[12:0]};
            @(posedge pclk);
            #3;
            fork
                aep_ssi_master_i.read_frame(r > 13 ? 17 : 13, r == 14 ? 60 : 40, w);
                begin
                    clks(10);
                    push(15'h1111, 0);
                end
            join
            `CHK("frame word", e, w);
            `CHK("idle data", 1, ssi_data);
        end
        $display("test serial frames done");
        stop_test;
    end
endmodule

bind aep_top aep_top_monitor #(.PW(PW), .ZERO_CYC(ZERO_CYC), .RPT_BCD(RPT_BCD),
    .MONO_CYC(MONO_CYC)) aep_top_monitor_i (.pclk(pclk), .presetn(presetn),
    .pos_ready(pos_ready), .drv_on_n(drv_on_n), .freeze_n(freeze_n), .zero_pin(zero_pin),
    .ssi_clk(ssi_clk), .ssi_data(ssi_data), .par_out(par_out), .par_oe(par_oe),
    .parity_out(parity_out));
